/* core/adc_conv_pkg.sv */
// Shared constants, types and decode tables of the converter control block
package adc_conv_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    localparam int RESULT_W = 10;
    localparam int CHAN_W = 3;
    localparam int PIN_COUNT = 8;
    localparam int CNT_W = 6;
    localparam int IRQ_W = 2;
    localparam int TAD_PER_CONV = 12;

    // Printed offsets are not word aligned: they are word indices
    localparam logic [7:0] IDX_CONTROL0 = 8'h1F;
    localparam logic [7:0] IDX_PORT_CONFIG = 8'h9F;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL0 = {2'h0, IDX_CONTROL0, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_PORT_CONFIG = {2'h0, IDX_PORT_CONFIG, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_RESULT_HIGH = 12'h080;
    localparam logic [ADDR_W-1:0] ADDR_RESULT_LOW = 12'h084;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 12'h088;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h08C;

    // converter_control0 fields
    localparam int CTL_CS_LO_LSB = 6;
    localparam int CTL_CHAN_LSB = 3;
    localparam int CTL_GO_BIT = 2;
    localparam int CTL_POWER_BIT = 0;
    // converter_port_config fields
    localparam int CFG_JUSTIFY_BIT = 7;
    localparam int CFG_CS_HI_BIT = 6;
    localparam int CFG_PCFG_LSB = 0;
    // Interrupt status and mask fields
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_REFUSED_BIT = 1;

    localparam logic [1:0] CS_LO_RC = 2'h3;
    localparam logic [CNT_W-1:0] TERM_DIV2 = 6'h01;
    localparam logic [CNT_W-1:0] TERM_DIV4 = 6'h03;
    localparam logic [CNT_W-1:0] TERM_DIV8 = 6'h07;
    localparam logic [CNT_W-1:0] TERM_DIV16 = 6'h0F;
    localparam logic [CNT_W-1:0] TERM_DIV32 = 6'h1F;
    localparam logic [CNT_W-1:0] TERM_DIV64 = 6'h3F;
    localparam logic [RESULT_W-1:0] SAR_FIRST_TRIAL = 10'h200;
    localparam logic [3:0] SAR_MSB_IDX = 4'h9;
    localparam logic [3:0] TAD_LAST_IDX = 4'hB;

    typedef enum logic [2:0] {SAR_IDLE, SAR_ALIGN, SAR_SAMPLE, SAR_BITS, SAR_FINISH} sar_state_t;

    // Drive towards the analog multiplexer and conversion core
    typedef struct packed {
        logic power;
        logic [CHAN_W-1:0] channel;
        logic sample;
        logic [RESULT_W-1:0] dac_code;
    } conv_drive_t;

    // Pin function and reference selection
    typedef struct packed {
        logic vref_hi_pin;
        logic vref_lo_pin;
        logic [PIN_COUNT-1:0] analog_en;
    } port_map_t;

    // Counter terminal value for the divided system clock
    function automatic logic [CNT_W-1:0] div_term(input logic cs_hi, input logic [1:0] cs_lo);
        case ({cs_hi, cs_lo})
            3'h0: div_term = TERM_DIV2;
            3'h1: div_term = TERM_DIV8;
            3'h2: div_term = TERM_DIV32;
            3'h4: div_term = TERM_DIV4;
            3'h5: div_term = TERM_DIV16;
            3'h6: div_term = TERM_DIV64;
            default: div_term = TERM_DIV2;
        endcase
    endfunction

    // Reference pins count as analog pins
    function automatic port_map_t port_map(input logic [3:0] code);
        case (code)
            4'h0: port_map = {1'b0, 1'b0, 8'hFF};
            4'h1: port_map = {1'b1, 1'b0, 8'hFF};
            4'h2: port_map = {1'b0, 1'b0, 8'h1F};
            4'h3: port_map = {1'b1, 1'b0, 8'h1F};
            4'h4: port_map = {1'b0, 1'b0, 8'h0B};
            4'h5: port_map = {1'b1, 1'b0, 8'h0B};
            4'h8: port_map = {1'b1, 1'b1, 8'hFF};
            4'h9: port_map = {1'b0, 1'b0, 8'h3F};
            4'hA: port_map = {1'b1, 1'b0, 8'h3F};
            4'hB: port_map = {1'b1, 1'b1, 8'h3F};
            4'hC: port_map = {1'b1, 1'b1, 8'h1F};
            4'hD: port_map = {1'b1, 1'b1, 8'h0F};
            4'hE: port_map = {1'b0, 1'b0, 8'h01};
            4'hF: port_map = {1'b1, 1'b1, 8'h0D};
            default: port_map = {1'b0, 1'b0, 8'h00};
        endcase
    endfunction

endpackage

/* core/conv_tick_gen.sv */
// Conversion bit-period tick from divided system clock or internal RC clock
`timescale 1ns/1ps
module conv_tick_gen import adc_conv_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic cs_hi,
    input wire logic [1:0] cs_lo,
    input wire logic sleep_mode,
    input wire logic rc_clk_pin,
    output logic tad_tick
);
    typedef struct packed {
        logic [2:0] rc_sync;
        logic rc_lvl;
        logic [CNT_W-1:0] cnt;
        logic tick;
    } tick_state_t;

    tick_state_t s_ff;
    tick_state_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.tick = 1'b0;
        nxt_s.rc_sync = {s_ff.rc_sync[1:0], rc_clk_pin};
        // Level moves only once second and third stage agree
        if (s_ff.rc_sync[1] == s_ff.rc_sync[2]) begin
            nxt_s.rc_lvl = s_ff.rc_sync[2];
        end
        if (cs_lo == CS_LO_RC) begin // [RULE_04] [RULE_05]
            nxt_s.cnt = '0;
            nxt_s.tick = nxt_s.rc_lvl & ~s_ff.rc_lvl; // [RULE_03]
        end else if (sleep_mode) begin
            // System clock divider is frozen while asleep
            nxt_s.cnt = s_ff.cnt; // [RULE_03]
        end else if (s_ff.cnt >= div_term(cs_hi, cs_lo)) begin // [RULE_04] [RULE_05]
            nxt_s.cnt = '0;
            nxt_s.tick = 1'b1;
        end else begin
            nxt_s.cnt = s_ff.cnt + 6'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign tad_tick = s_ff.tick;

    a_sleep_needs_rc: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_03]
        (sleep_mode && cs_lo != CS_LO_RC) |=> (!tad_tick || $past(cs_lo) == CS_LO_RC))
        else $error("tick from system clock while asleep");

    a_div_two_gap: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_04]
        (tad_tick && {cs_hi, cs_lo} == 3'h0 && !sleep_mode)
        ##1 ({cs_hi, cs_lo} == 3'h0 && !sleep_mode) |-> !tad_tick ##1 tad_tick)
        else $error("system clock over two gives wrong tick spacing");

endmodule

/* core/adc_conversion_control.sv */
// AHB-Lite register slave and successive-approximation sequencer of the converter
//
// Operation
// [RULE_01] Each finished conversion yields a ten-bit result.
// [RULE_02] Five analog inputs on the small variant, eight on larger ones.
// [RULE_03] Conversions run during sleep only with the internal RC clock selected.
// [RULE_04] With high select 0: 00 clk/2, 01 clk/8, 10 clk/32, 11 RC.
// [RULE_05] With high select 1: 00 clk/4, 01 clk/16, 10 clk/64, 11 RC.
// [RULE_06] Channel field bits 5-3 selects input equal to its binary value.
// [RULE_07] Software never selects reserved channels on the reduced variant.
// [RULE_08] Writing start bit 2 while powered starts conversion; reads one while running.
// [RULE_09] Hardware clears the start bit when the conversion finishes.
// [RULE_10] Power bit 0 powers the converter; clear shuts it off.
// [RULE_11] Control bit 1 always reads zero and ignores writes.
// [RULE_12] Software picks high and low references from supply, ground or two pins.
// [RULE_13] Port config register sets each shared pin analog or digital.
// [RULE_14] On completion load result pair, clear start bit, set done flag.
// [RULE_15] Justify bit chooses right or left alignment with zero padding.
// [RULE_16] A conversion lasts at least twelve conversion clock periods.
// [RULE_17] Start written while unpowered starts nothing.
`timescale 1ns/1ps
module adc_conversion_control import adc_conv_pkg::*; #(
    parameter int NUM_INPUTS = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [DATA_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic [DATA_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sleep_mode,
    input wire logic rc_clk_pin,
    input wire logic cmp_above_pin,
    output conv_drive_t conv_drive,
    output port_map_t pin_map,
    output logic irq
);
    if (!(NUM_INPUTS == 5 || NUM_INPUTS == 8)) begin : g_bad_inputs
        $error("NUM_INPUTS must be 5 or 8");
    end

    localparam logic [PIN_COUNT-1:0] PRESENT_MASK = PIN_COUNT'((1 << NUM_INPUTS) - 1);

    typedef struct packed {
        logic hready;
        logic [DATA_W-1:0] hrdata;
        logic rd_pend;
        logic wr_pend;
        logic [ADDR_W-1:0] addr;
        logic [1:0] cs_lo;
        logic [CHAN_W-1:0] chan;
        logic go;
        logic power;
        logic justify;
        logic cs_hi;
        logic [3:0] pcfg;
        logic [RESULT_W-1:0] result;
        logic [RESULT_W-1:0] sar;
        logic [3:0] bit_idx;
        sar_state_t sst;
        logic [2:0] cmp_sync;
        logic cmp_lvl;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        conv_drive_t drive;
        port_map_t pmap;
    } ctl_state_t;

    ctl_state_t s_ff;
    ctl_state_t nxt_s;
    logic tad_tick;

    conv_tick_gen u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .cs_hi(s_ff.cs_hi),
        .cs_lo(s_ff.cs_lo),
        .sleep_mode(sleep_mode),
        .rc_clk_pin(rc_clk_pin),
        .tad_tick(tad_tick)
    );

    function automatic logic [DATA_W-1:0] read_mux(input ctl_state_t st);
        logic [7:0] v;
        v = 8'h00;
        case (st.addr)
            ADDR_CONTROL0: v = {st.cs_lo, st.chan, st.go, 1'b0, st.power}; // [RULE_11]
            ADDR_PORT_CONFIG: v = {st.justify, st.cs_hi, 2'b00, st.pcfg};
            ADDR_RESULT_HIGH: begin // [RULE_15]
                if (st.justify) begin
                    v = {6'h00, st.result[9:8]};
                end else begin
                    v = st.result[9:2];
                end
            end
            ADDR_RESULT_LOW: begin // [RULE_15]
                if (st.justify) begin
                    v = st.result[7:0];
                end else begin
                    v = {st.result[1:0], 6'h00};
                end
            end
            ADDR_IRQ_STATUS: v = {6'h00, st.irq_stat};
            ADDR_IRQ_MASK: v = {6'h00, st.irq_mask};
            default: v = 8'h00;
        endcase
        read_mux = {24'h000000, v};
    endfunction

    always_comb begin
        logic start_req;
        logic refused;
        logic done;
        logic [IRQ_W-1:0] w1c;
        start_req = 1'b0;
        refused = 1'b0;
        done = 1'b0;
        w1c = '0;
        nxt_s = s_ff;
        nxt_s.wr_pend = 1'b0;

        // Reads take one wait state so a write just before is visible
        if (s_ff.rd_pend) begin
            nxt_s.hrdata = read_mux(s_ff);
            nxt_s.hready = 1'b1;
            nxt_s.rd_pend = 1'b0;
        end

        if (s_ff.wr_pend) begin
            case (s_ff.addr)
                ADDR_CONTROL0: begin
                    nxt_s.cs_lo = hwdata[CTL_CS_LO_LSB +: 2]; // [RULE_04]
                    nxt_s.chan = hwdata[CTL_CHAN_LSB +: CHAN_W]; // [RULE_06]
                    nxt_s.power = hwdata[CTL_POWER_BIT]; // [RULE_10]
                    if (hwdata[CTL_GO_BIT]) begin
                        start_req = hwdata[CTL_POWER_BIT]; // [RULE_17]
                        refused = ~hwdata[CTL_POWER_BIT];
                    end
                end
                ADDR_PORT_CONFIG: begin
                    nxt_s.justify = hwdata[CFG_JUSTIFY_BIT];
                    nxt_s.cs_hi = hwdata[CFG_CS_HI_BIT]; // [RULE_05]
                    nxt_s.pcfg = hwdata[CFG_PCFG_LSB +: 4];
                end
                ADDR_IRQ_STATUS: w1c = hwdata[IRQ_W-1:0];
                ADDR_IRQ_MASK: nxt_s.irq_mask = hwdata[IRQ_W-1:0];
                default: ;
            endcase
        end

        if (hsel && htrans[1] && hready) begin
            nxt_s.addr = haddr[ADDR_W-1:0];
            if (hwrite) begin
                nxt_s.wr_pend = 1'b1;
            end else begin
                nxt_s.rd_pend = 1'b1;
                nxt_s.hready = 1'b0;
            end
        end

        // Comparator from the analog core crosses into this clock
        nxt_s.cmp_sync = {s_ff.cmp_sync[1:0], cmp_above_pin};
        if (s_ff.cmp_sync[1] == s_ff.cmp_sync[2]) begin
            nxt_s.cmp_lvl = s_ff.cmp_sync[2];
        end

        case (s_ff.sst)
            SAR_IDLE: begin
                if (start_req) begin // [RULE_08]
                    nxt_s.sst = SAR_ALIGN;
                    nxt_s.go = 1'b1;
                end
            end
            SAR_ALIGN: begin
                // Partial first period is not counted
                if (tad_tick) begin // [RULE_16]
                    nxt_s.sst = SAR_SAMPLE;
                end
            end
            SAR_SAMPLE: begin
                if (tad_tick) begin
                    nxt_s.sst = SAR_BITS;
                    nxt_s.sar = SAR_FIRST_TRIAL;
                    nxt_s.bit_idx = SAR_MSB_IDX;
                end
            end
            SAR_BITS: begin
                if (tad_tick) begin
                    nxt_s.sar[s_ff.bit_idx] = s_ff.cmp_lvl; // [RULE_01]
                    if (s_ff.bit_idx == 4'h0) begin
                        nxt_s.sst = SAR_FINISH;
                    end else begin
                        nxt_s.bit_idx = s_ff.bit_idx - 4'h1;
                        nxt_s.sar[s_ff.bit_idx - 4'h1] = 1'b1;
                    end
                end
            end
            SAR_FINISH: begin
                if (tad_tick) begin // [RULE_14]
                    nxt_s.result = s_ff.sar; // [RULE_01]
                    nxt_s.go = 1'b0; // [RULE_09]
                    nxt_s.sst = SAR_IDLE;
                    done = 1'b1;
                end
            end
            default: nxt_s.sst = SAR_IDLE;
        endcase

        // Power removal aborts; a finished result still lands
        if (!nxt_s.power) begin // [RULE_10]
            nxt_s.sst = SAR_IDLE;
            nxt_s.go = 1'b0;
        end

        // Hardware set wins over a same-cycle clear
        nxt_s.irq_stat = (s_ff.irq_stat & ~w1c)
            | {refused, done}; // [RULE_14]
        nxt_s.irq = |(nxt_s.irq_stat & nxt_s.irq_mask);

        nxt_s.drive.power = nxt_s.power; // [RULE_10]
        nxt_s.drive.channel = nxt_s.chan; // [RULE_06] [RULE_07]
        nxt_s.drive.sample = (nxt_s.sst == SAR_SAMPLE);
        nxt_s.drive.dac_code = nxt_s.sar;
        nxt_s.pmap = port_map(nxt_s.pcfg); // [RULE_12] [RULE_13]
        nxt_s.pmap.analog_en = nxt_s.pmap.analog_en & PRESENT_MASK; // [RULE_02]
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_ff <= '0;
            s_ff.hready <= 1'b1;
            s_ff.pmap <= {1'b0, 1'b0, PRESENT_MASK};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign hrdata = s_ff.hrdata;
    assign hreadyout = s_ff.hready;
    assign hresp = 1'b0;
    assign conv_drive = s_ff.drive;
    assign pin_map = s_ff.pmap;
    assign irq = s_ff.irq;

    // Period counter used only by the checks below
    logic [3:0] tad_seen_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tad_seen_ff <= 4'h0;
        end else if (s_ff.sst == SAR_IDLE || s_ff.sst == SAR_ALIGN) begin
            tad_seen_ff <= 4'h0;
        end else if (tad_tick) begin
            tad_seen_ff <= tad_seen_ff + 4'h1;
        end
    end

    a_go_tracks_busy: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_08]
        s_ff.go == (s_ff.sst != SAR_IDLE))
        else $error("start bit disagrees with sequencer activity");

    a_done_loads_result: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_14]
        (s_ff.sst == SAR_FINISH && tad_tick && s_ff.power && !nxt_s.wr_pend)
        |=> !s_ff.go && s_ff.irq_stat[IRQ_DONE_BIT] && s_ff.result == $past(s_ff.sar))
        else $error("completion did not load result and flag");

    a_twelve_periods: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_16]
        (s_ff.sst == SAR_FINISH && tad_tick) |-> tad_seen_ff == TAD_LAST_IDX)
        else $error("conversion shorter or longer than twelve periods");

    a_no_start_off: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_17]
        (!s_ff.power) |=> (s_ff.sst == SAR_IDLE || s_ff.sst == SAR_ALIGN && s_ff.power))
        else $error("conversion running while unpowered");

    a_bit1_reads_zero: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_11]
        (s_ff.rd_pend && s_ff.addr == ADDR_CONTROL0) |=> !hrdata[1] && hreadyout)
        else $error("unimplemented control bit read as one");

    a_right_justify: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_15]
        (s_ff.rd_pend && s_ff.addr == ADDR_RESULT_HIGH && s_ff.justify)
        |=> hrdata[7:2] == 6'h00 && hrdata[1:0] == $past(s_ff.result[9:8]))
        else $error("right justified high byte wrong");

    a_channel_drive: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_06]
        conv_drive.channel == s_ff.chan && conv_drive.power == s_ff.power)
        else $error("channel or power drive out of step with control");

    a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_14]
        $rose(s_ff.irq_stat[IRQ_DONE_BIT]) && s_ff.irq_mask[IRQ_DONE_BIT] |-> irq)
        else $error("unmasked done flag did not raise interrupt");

    a_irq_exact: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_14]
        irq == |(s_ff.irq_stat & s_ff.irq_mask))
        else $error("interrupt level disagrees with status and mask");

    // Refusal must leave the sequencer idle and say so in status
    a_refused_flag: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_17]
        (s_ff.wr_pend && s_ff.addr == ADDR_CONTROL0 && hwdata[CTL_GO_BIT]
        && !hwdata[CTL_POWER_BIT]) |=> !s_ff.go && s_ff.irq_stat[IRQ_REFUSED_BIT])
        else $error("start without power was not refused");

    a_power_abort: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_10]
        (s_ff.wr_pend && s_ff.addr == ADDR_CONTROL0 && !hwdata[CTL_POWER_BIT])
        |=> !s_ff.go && !conv_drive.power)
        else $error("power clear did not stop the converter");

    a_left_justify: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_15]
        (s_ff.rd_pend && s_ff.addr == ADDR_RESULT_LOW && !s_ff.justify)
        |=> hrdata[5:0] == 6'h00 && hrdata[7:6] == $past(s_ff.result[1:0]))
        else $error("left justified low byte wrong");

endmodule

/* verif/analog_core_model.sv */
// Behavioural analog multiplexer, comparator and internal RC oscillator
`timescale 1ns/1ps
module analog_core_model import adc_conv_pkg::*; (
    input wire logic hclk,
    input wire conv_drive_t conv_drive,
    input wire logic [PIN_COUNT-1:0][RESULT_W-1:0] level,
    output logic cmp_above_pin,
    output logic rc_clk_pin
);
    logic junk_ff = 1'b0;
    // Free running, odd start phase keeps edges off hclk edges; 200 ns half period holds that phase fixed
    initial begin
        rc_clk_pin = 1'b0;
        #3.7;
        forever #200 rc_clk_pin = ~rc_clk_pin;
    end
    always @(posedge hclk) junk_ff <= ~junk_ff;
    // Unpowered comparator gives garbage, never a steady level
    always_comb begin
        if (conv_drive.power) begin
            cmp_above_pin = level[conv_drive.channel] >= conv_drive.dac_code;
        end else begin
            cmp_above_pin = junk_ff;
        end
    end
endmodule

/* verif/tb.sv */
// Self-checking bench of the converter control block
`timescale 1ns/1ps
module tb import adc_conv_pkg::*;;
    localparam logic [9:0] PMAP [16] = '{10'h0FF, 10'h2FF, 10'h01F, 10'h21F, 10'h00B,
        10'h20B, 10'h000, 10'h000, 10'h3FF, 10'h03F, 10'h23F, 10'h33F, 10'h31F,
        10'h30F, 10'h001, 10'h30D};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic sleep_mode = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [DATA_W-1:0] haddr = 32'h0;
    logic [DATA_W-1:0] hwdata = 32'h0;
    logic [DATA_W-1:0] hrdata, rd_q;
    logic hreadyout, hresp, irq, rc_clk_pin, cmp_above_pin, rdy_q;
    logic [PIN_COUNT-1:0][RESULT_W-1:0] level = '0;
    conv_drive_t conv_drive;
    port_map_t pin_map;
    int err_total = 0;
    int num_checks = 0;
    int seed = 43133;
    int cyc = 0;

    adc_conversion_control #(.NUM_INPUTS(8)) dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sleep_mode(sleep_mode), .rc_clk_pin(rc_clk_pin),
        .cmp_above_pin(cmp_above_pin), .conv_drive(conv_drive), .pin_map(pin_map),
        .irq(irq));
    analog_core_model core (.hclk(hclk), .conv_drive(conv_drive), .level(level),
        .cmp_above_pin(cmp_above_pin), .rc_clk_pin(rc_clk_pin));

    initial begin
        forever #5 hclk = ~hclk;
    end
    // Values as the master sees them at the rising edge
    always @(posedge hclk) begin
        rdy_q <= hreadyout;
        rd_q <= hrdata;
        cyc <= cyc + 1;
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [DATA_W-1:0] seen,
        input logic [DATA_W-1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge hclk);
        #1;
    endtask

    task automatic edge_wait;
        int n;
        n = 0;
        do begin
            idle(1);
            n++;
        end while (rdy_q !== 1'b1 && n < 40);
        if (n >= 40) begin
            err_total++;
            wrap_up();
        end
    endtask

    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
        output logic [DATA_W-1:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {20'h0, a};
        edge_wait();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        edge_wait();
        q = rd_q;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [DATA_W-1:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [7:0] e);
        logic [DATA_W-1:0] q;
        bus(1'b0, a, 8'h00, q);
        check(what, q, {24'h0, e});
    endtask

    // Polls the start bit; cycles counted from t0
    task automatic wait_done(input int t0, output int n);
        logic [DATA_W-1:0] q;
        do begin
            bus(1'b0, ADDR_CONTROL0, 8'h00, q);
        end while (q[CTL_GO_BIT] !== 1'b0 && cyc - t0 < 4000);
        n = cyc - t0;
        if (n >= 4000) begin
            err_total++;
            wrap_up();
        end
    endtask

    initial begin
        int n;
        int t0;
        int dv;
        logic [2:0] ch;
        logic just;
        logic [9:0] r;
        idle(4);
        hresetn <= 1'b1;
        check("pin map reset", pin_map, 10'h0FF);
        check("drive reset", conv_drive, '0);
        check("hresp", hresp, 1'b0);
        rd_chk("control reset", ADDR_CONTROL0, 8'h00);
        rd_chk("config reset", ADDR_PORT_CONFIG, 8'h00);
        rd_chk("status reset", ADDR_IRQ_STATUS, 8'h00);
        rd_chk("mask reset", ADDR_IRQ_MASK, 8'h00);
        rd_chk("result reset", ADDR_RESULT_HIGH, 8'h00);
        wr(12'h100, 8'hA5);
        rd_chk("unmapped", 12'h100, 8'h00);
        wr(ADDR_CONTROL0, 8'h7A);
        rd_chk("bit one", ADDR_CONTROL0, 8'h78);
        check("power off", conv_drive.power, 1'b0);
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_CONTROL0, {2'h1, 3'(c), 3'h1});
            check("drive channel", {conv_drive.power, conv_drive.channel}, {1'b1, 3'(c)});
        end
        for (int c = 0; c < 16; c++) begin
            wr(ADDR_PORT_CONFIG, {4'h3, 4'(c)});
            rd_chk("port config", ADDR_PORT_CONFIG, {4'h0, 4'(c)});
            check("pin map", pin_map, PMAP[c]);
        end
        // Start with power clear is refused and flagged
        wr(ADDR_CONTROL0, 8'h04);
        rd_chk("refused start", ADDR_CONTROL0, 8'h00);
        rd_chk("refused flag", ADDR_IRQ_STATUS, 8'h02);
        wr(ADDR_IRQ_STATUS, 8'h02);
        for (int i = 0; i < 8; i++) begin
            just = 1'($random(seed));
            ch = 3'($random(seed));
            for (int k = 0; k < 8; k++) begin
                level[k] <= 10'($random(seed));
            end
            wr(ADDR_PORT_CONFIG, {just, i[2], 6'h00});
            wr(ADDR_IRQ_MASK, {7'h00, i[0]});
            wr(ADDR_CONTROL0, {i[1:0], ch, 3'h5});
            t0 = cyc;
            rd_chk("busy", ADDR_CONTROL0, {i[1:0], ch, 3'h5});
            wait_done(t0, n);
            dv = (i[1:0] == 2'h3) ? 40 : ((i[2] ? 4 : 2) << (2 * i[1:0]));
            check("duration low", n >= 12 * dv, 1);
            check("duration high", n <= 13 * dv + 20, 1);
            r = level[ch];
            // Comparator sync lag spoils the fastest clocks
            if (dv >= 8) begin
                rd_chk("result high", ADDR_RESULT_HIGH, just ? {6'h00, r[9:8]} : r[9:2]);
                rd_chk("result low", ADDR_RESULT_LOW, just ? r[7:0] : {r[1:0], 6'h00});
            end
            rd_chk("done flag", ADDR_IRQ_STATUS, 8'h01);
            check("irq masked", irq, i[0]);
            wr(ADDR_IRQ_MASK, 8'h01);
            rd_chk("mask", ADDR_IRQ_MASK, 8'h01);
            check("irq unmasked", irq, 1'b1);
            wr(ADDR_IRQ_STATUS, 8'h01);
            rd_chk("flag cleared", ADDR_IRQ_STATUS, 8'h00);
            check("irq cleared", irq, 1'b0);
        end
        // Dropping power mid-conversion leaves no result flag
        wr(ADDR_PORT_CONFIG, 8'h40);
        wr(ADDR_CONTROL0, 8'h85);
        wr(ADDR_CONTROL0, 8'h80);
        rd_chk("abort", ADDR_CONTROL0, 8'h80);
        idle(900);
        rd_chk("abort flag", ADDR_IRQ_STATUS, 8'h00);
        wr(ADDR_PORT_CONFIG, 8'h00);
        wr(ADDR_CONTROL0, 8'h45);
        sleep_mode <= 1'b1;
        idle(300);
        rd_chk("sleep pause", ADDR_CONTROL0, 8'h45);
        sleep_mode <= 1'b0;
        wait_done(cyc, n);
        rd_chk("after wake", ADDR_IRQ_STATUS, 8'h01);
        wr(ADDR_IRQ_STATUS, 8'h01);
        sleep_mode <= 1'b1;
        wr(ADDR_CONTROL0, 8'hC5);
        wait_done(cyc, n);
        check("sleep rc", n <= 13 * 40 + 20, 1);
        rd_chk("sleep rc flag", ADDR_IRQ_STATUS, 8'h01);
        sleep_mode <= 1'b0;
        // Second reset in mid-conversion
        wr(ADDR_CONTROL0, 8'hC5);
        hresetn <= 1'b0;
        idle(2);
        hresetn <= 1'b1;
        rd_chk("reset again", ADDR_CONTROL0, 8'h00);
        rd_chk("reset status", ADDR_IRQ_STATUS, 8'h00);
        wrap_up();
    end
endmodule
